// *** fesb_pkg.sv ***
// Package of offsets, field positions and reset values for the fault and event status bank
package fesb_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int unsigned FESB_DATA_W = 8;
    localparam int unsigned FESB_ADDR_W = 8;
    localparam int unsigned FESB_LIVE_W = 5;
    localparam int unsigned FESB_OVL_W = 2;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] FESB_OFS_CH2_FAULT = 8'h37;
    localparam logic [7:0] FESB_OFS_OVL_MASK = 8'h38;
    localparam logic [7:0] FESB_OFS_HEADSET = 8'h3a;
    localparam logic [7:0] FESB_OFS_BIAS = 8'h3b;
    localparam logic [7:0] FESB_OFS_LIVE = 8'h3c;

    // ****************************************************************
    // Reset values and fixed patterns
    // ****************************************************************
    localparam logic [7:0] FESB_RST_CH2_FAULT = 8'h00;
    localparam logic [7:0] FESB_RST_OVL_MASK = 8'h00;
    localparam logic [7:0] FESB_RST_HEADSET = 8'h00;
    localparam logic [7:0] FESB_RST_BIAS = 8'h00;
    localparam logic [7:0] FESB_RST_LIVE = 8'h00;
    localparam logic [7:0] FESB_UNMAPPED_DATA = 8'h00;
    localparam logic [7:0] FESB_OVL_MASK_WR = 8'h0c;
    localparam logic [2:0] FESB_LIVE_RSVD = 3'h0;

    // ****************************************************************
    // Channel-2 input fault fields
    // ****************************************************************
    localparam int unsigned FESB_CH2_OPEN_BIT = 7;
    localparam int unsigned FESB_CH2_SHORTED_BIT = 6;
    localparam int unsigned FESB_CH2_POS_GND_BIT = 5;
    localparam int unsigned FESB_CH2_NEG_GND_BIT = 4;
    localparam int unsigned FESB_CH2_POS_BIAS_BIT = 3;
    localparam int unsigned FESB_CH2_NEG_BIAS_BIT = 2;
    localparam int unsigned FESB_CH2_POS_BAT_BIT = 1;
    localparam int unsigned FESB_CH2_NEG_BAT_BIT = 0;

    // ****************************************************************
    // Overload mask fields and overload input order
    // ****************************************************************
    localparam int unsigned FESB_CH1_OVL_MASK_BIT = 3;
    localparam int unsigned FESB_CH2_OVL_MASK_BIT = 2;
    localparam int unsigned FESB_OVL_CH1 = 1;
    localparam int unsigned FESB_OVL_CH2 = 0;

    // ****************************************************************
    // Input and headset event fields
    // ****************************************************************
    localparam int unsigned FESB_CH1_POS_OV_BIT = 7;
    localparam int unsigned FESB_CH1_NEG_OV_BIT = 6;
    localparam int unsigned FESB_CH2_POS_OV_BIT = 5;
    localparam int unsigned FESB_CH2_NEG_OV_BIT = 4;
    localparam int unsigned FESB_HS_INSERT_BIT = 3;
    localparam int unsigned FESB_HS_REMOVE_BIT = 2;
    localparam int unsigned FESB_HS_BUTTON_BIT = 1;
    localparam int unsigned FESB_LOAD_OVL_BIT = 0;

    // ****************************************************************
    // Threshold and bias event fields
    // ****************************************************************
    localparam int unsigned FESB_GPA_UP_BIT = 7;
    localparam int unsigned FESB_GPA_LOW_BIT = 6;
    localparam int unsigned FESB_VAD_UP_BIT = 5;
    localparam int unsigned FESB_VAD_DOWN_BIT = 4;
    localparam int unsigned FESB_BIAS_SHORT_BIT = 3;
    localparam int unsigned FESB_BIAS_HI_CUR_BIT = 2;
    localparam int unsigned FESB_BIAS_LO_CUR_BIT = 1;
    localparam int unsigned FESB_BIAS_OV_BIT = 0;

    // ****************************************************************
    // Live clock and boost fields
    // ****************************************************************
    localparam int unsigned FESB_LIVE_CLK_ERR_BIT = 7;
    localparam int unsigned FESB_LIVE_LOCK_BIT = 6;
    localparam int unsigned FESB_LIVE_BOOST_TEMP_BIT = 5;
    localparam int unsigned FESB_LIVE_BOOST_CUR_BIT = 4;
    localparam int unsigned FESB_LIVE_BOOST_FAULT_BIT = 3;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic fesb_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

endpackage

// *** fesb_latch_if.sv ***
// Interface between the status bank and one latched event register
interface fesb_latch_if;
    logic [7:0] set_evt;
    logic rd_clr;
    logic [7:0] value;

    modport bank (
        input set_evt,
        input rd_clr,
        output value
    );
    modport owner (
        output set_evt,
        output rd_clr,
        input value
    );
endinterface

// *** fesb_latch_bank.sv ***
// One latched event register, cleared by a read, with set taking priority
module fesb_latch_bank #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input logic sys_clk,
    input logic rst,
    fesb_latch_if.bank lb
);

    logic [7:0] value_q;
    logic [7:0] value_d;

    // ****************************************************************
    // Sticky bits
    // ****************************************************************
    always_comb begin
        value_d = lb.set_evt | (value_q & ~{8{lb.rd_clr}});
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            value_q <= RST_VAL;
        end else begin
            value_q <= value_d;
        end
    end

    assign lb.value = value_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_latch_hold;
        @(posedge sys_clk) disable iff (rst)
        (!lb.rd_clr ##0 value_q != 8'h00) |=> ((value_q & $past(value_q)) == $past(value_q));
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Latched bit lost without a read");

    property p_latch_clear;
        @(posedge sys_clk) disable iff (rst)
        lb.rd_clr |=> (value_q == $past(lb.set_evt));
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("Read did not clear to the present conditions");

    c_set_on_read: cover property (@(posedge sys_clk) disable iff (rst)
        lb.rd_clr && (lb.set_evt & value_q) != 8'h00);

endmodule

// *** fesb_fault_event_status_bank.sv ***
// Fault and event status bank: latched and live status registers and overload masks
// Functional notes
// - Channel-2 open input sets latched fault bit 7, cleared later by reading.
// - Channel-2 inputs shorted together set latched fault bit 6, cleared later by reading.
// - Channel-2 positive and negative shorts to ground set bits 5 and 4.
// - Channel-2 positive and negative shorts to bias supply set bits 3 and 2.
// - Channel-2 positive and negative shorts to battery set bits 1 and 0.
// - Mask register bit 3 masks channel-1 converter overload; resets to 0.
// - Mask register bit 2 masks channel-2 converter overload; resets to 0.
// - Channel-1 positive and negative over-voltage set first event bits 7 and 6.
// - Channel-2 positive and negative over-voltage set first event bits 5 and 4.
// - Headset insertion sets first event bit 3, cleared later by reading.
// - Headset removal sets first event bit 2, cleared later by reading.
// - Headset hook button press sets first event bit 1, cleared later by reading.
// - Processing load overflow sets first event bit 0, cleared later by reading.
// - General-purpose input upper and lower threshold set second event bits 7, 6.
// - Voice activity power-up and power-down detects set second event bits 5, 4.
// - Bias output short circuit sets second event bit 3, cleared later by reading.
// - Bias high and low current faults set second event bits 2 and 1.
// - Bias over-voltage sets second event bit 0, cleared later by reading.
// - Live register bits 7..3 show clock and boost conditions; 2..0 read zero.
module fesb_fault_event_status_bank (
    input logic sys_clk,
    input logic rst,
    input logic [7:0] reg_addr,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    input logic [7:0] ch2_fault_raw,
    input logic [7:0] headset_event_raw,
    input logic [7:0] bias_event_raw,
    input logic [4:0] clock_boost_raw,
    input logic [1:0] overload_raw,
    output logic ch1_overload_irq_q,
    output logic ch2_overload_irq_q
);

    // ****************************************************************
    // Synchronisers for detector levels
    // ****************************************************************
    logic [7:0] ch2_meta_q;
    logic [7:0] ch2_sync_q;
    logic [7:0] hs_meta_q;
    logic [7:0] hs_sync_q;
    logic [7:0] bias_meta_q;
    logic [7:0] bias_sync_q;
    logic [4:0] live_meta_q;
    logic [4:0] live_sync_q;
    logic [1:0] ovl_meta_q;
    logic [1:0] ovl_sync_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ch2_meta_q <= 8'h00;
            ch2_sync_q <= 8'h00;
            hs_meta_q <= 8'h00;
            hs_sync_q <= 8'h00;
            bias_meta_q <= 8'h00;
            bias_sync_q <= 8'h00;
            live_meta_q <= 5'h00;
            live_sync_q <= 5'h00;
            ovl_meta_q <= 2'h0;
            ovl_sync_q <= 2'h0;
        end else begin
            ch2_meta_q <= ch2_fault_raw;
            ch2_sync_q <= ch2_meta_q;
            hs_meta_q <= headset_event_raw;
            hs_sync_q <= hs_meta_q;
            bias_meta_q <= bias_event_raw;
            bias_sync_q <= bias_meta_q;
            live_meta_q <= clock_boost_raw;
            live_sync_q <= live_meta_q;
            ovl_meta_q <= overload_raw;
            ovl_sync_q <= ovl_meta_q;
        end
    end

    // ****************************************************************
    // Register port decode
    // ****************************************************************
    logic rd_ch2;
    logic rd_hs;
    logic rd_bias;
    logic wr_mask;

    always_comb begin
        rd_ch2 = reg_rd && fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_CH2_FAULT);
        rd_hs = reg_rd && fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_HEADSET);
        rd_bias = reg_rd && fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_BIAS);
        wr_mask = reg_wr && fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_OVL_MASK);
    end

    // ****************************************************************
    // Latched event registers
    // ****************************************************************
    fesb_latch_if ch2_if();
    fesb_latch_if hs_if();
    fesb_latch_if bias_if();

    always_comb begin
        ch2_if.set_evt = ch2_sync_q;
        ch2_if.rd_clr = rd_ch2;
        hs_if.set_evt = hs_sync_q;
        hs_if.rd_clr = rd_hs;
        bias_if.set_evt = bias_sync_q;
        bias_if.rd_clr = rd_bias;
    end

    fesb_latch_bank #(
        .RST_VAL(fesb_pkg::FESB_RST_CH2_FAULT)
    ) u_ch2_fault (
        .sys_clk(sys_clk),
        .rst(rst),
        .lb(ch2_if.bank)
    );

    fesb_latch_bank #(
        .RST_VAL(fesb_pkg::FESB_RST_HEADSET)
    ) u_headset (
        .sys_clk(sys_clk),
        .rst(rst),
        .lb(hs_if.bank)
    );

    fesb_latch_bank #(
        .RST_VAL(fesb_pkg::FESB_RST_BIAS)
    ) u_bias (
        .sys_clk(sys_clk),
        .rst(rst),
        .lb(bias_if.bank)
    );

    // ****************************************************************
    // Overload mask register
    // ****************************************************************
    logic [7:0] ovl_mask_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ovl_mask_q <= fesb_pkg::FESB_RST_OVL_MASK;
        end else if (wr_mask) begin
            // Reserved bits never store, so they read as zero
            ovl_mask_q <= reg_wdata & fesb_pkg::FESB_OVL_MASK_WR;
        end
    end

    // ****************************************************************
    // Overload indications
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ch1_overload_irq_q <= 1'b0;
            ch2_overload_irq_q <= 1'b0;
        end else begin
            ch1_overload_irq_q <= ovl_sync_q[fesb_pkg::FESB_OVL_CH1]
                && !ovl_mask_q[fesb_pkg::FESB_CH1_OVL_MASK_BIT];
            ch2_overload_irq_q <= ovl_sync_q[fesb_pkg::FESB_OVL_CH2]
                && !ovl_mask_q[fesb_pkg::FESB_CH2_OVL_MASK_BIT];
        end
    end

    // ****************************************************************
    // Live register and read data
    // ****************************************************************
    logic [7:0] live_value;
    logic [7:0] rdata_d;

    always_comb begin
        live_value = {live_sync_q, fesb_pkg::FESB_LIVE_RSVD};
    end

    always_comb begin
        rdata_d = fesb_pkg::FESB_UNMAPPED_DATA;
        if (fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_CH2_FAULT)) begin
            rdata_d = ch2_if.value;
        end else if (fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_OVL_MASK)) begin
            rdata_d = ovl_mask_q;
        end else if (fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_HEADSET)) begin
            rdata_d = hs_if.value;
        end else if (fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_BIAS)) begin
            rdata_d = bias_if.value;
        end else if (fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_LIVE)) begin
            rdata_d = live_value;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_ch2_latch;
        ch2_sync_q != 8'h00 |=> ((ch2_if.value & $past(ch2_sync_q)) == $past(ch2_sync_q));
    endproperty
    a_ch2_latch: assert property (p_ch2_latch)
        else $error("Channel-2 fault condition not latched");

    property p_ch2_open_seen;
        (ch2_fault_raw[fesb_pkg::FESB_CH2_OPEN_BIT] && !rd_ch2) [*3]
            |=> ch2_if.value[fesb_pkg::FESB_CH2_OPEN_BIT];
    endproperty
    a_ch2_open_seen: assert property (p_ch2_open_seen)
        else $error("Open input not shown after the synchroniser delay");

    property p_hs_latch;
        hs_sync_q != 8'h00 |=> ((hs_if.value & $past(hs_sync_q)) == $past(hs_sync_q));
    endproperty
    a_hs_latch: assert property (p_hs_latch)
        else $error("Input or headset event not latched");

    property p_bias_latch;
        bias_sync_q != 8'h00 |=> ((bias_if.value & $past(bias_sync_q)) == $past(bias_sync_q));
    endproperty
    a_bias_latch: assert property (p_bias_latch)
        else $error("Threshold or bias event not latched");

    property p_read_clears;
        rd_hs && hs_sync_q == 8'h00 ##1 hs_sync_q == 8'h00 |=> hs_if.value == 8'h00;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("Headset event register not cleared by read");

    property p_read_returns;
        rd_ch2 |=> reg_rdata_q == $past(ch2_if.value);
    endproperty
    a_read_returns: assert property (p_read_returns)
        else $error("Read data differs from latched value");

    property p_live_read;
        reg_rd && fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_LIVE)
            |=> reg_rdata_q == {$past(live_sync_q), 3'h0};
    endproperty
    a_live_read: assert property (p_live_read)
        else $error("Live register read wrong");

    property p_mask_write;
        wr_mask |=> ovl_mask_q == ($past(reg_wdata) & 8'h0c);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("Mask register did not take the write");

    property p_mask_reserved;
        reg_rd && fesb_pkg::fesb_hit(reg_addr, fesb_pkg::FESB_OFS_OVL_MASK)
            |=> (reg_rdata_q & 8'hf3) == 8'h00;
    endproperty
    a_mask_reserved: assert property (p_mask_reserved)
        else $error("Reserved mask bits read nonzero");

    property p_ch1_masked;
        ovl_mask_q[fesb_pkg::FESB_CH1_OVL_MASK_BIT] |=> !ch1_overload_irq_q;
    endproperty
    a_ch1_masked: assert property (p_ch1_masked)
        else $error("Masked channel-1 overload raised indication");

    property p_ch2_unmasked;
        ovl_sync_q[fesb_pkg::FESB_OVL_CH2] && !ovl_mask_q[fesb_pkg::FESB_CH2_OVL_MASK_BIT]
            |=> ch2_overload_irq_q;
    endproperty
    a_ch2_unmasked: assert property (p_ch2_unmasked)
        else $error("Unmasked channel-2 overload not indicated");

    property p_ch2_masked;
        ovl_mask_q[fesb_pkg::FESB_CH2_OVL_MASK_BIT] |=> !ch2_overload_irq_q;
    endproperty
    a_ch2_masked: assert property (p_ch2_masked)
        else $error("Masked channel-2 overload raised indication");

    property p_ch1_unmasked;
        ovl_sync_q[fesb_pkg::FESB_OVL_CH1] && !ovl_mask_q[fesb_pkg::FESB_CH1_OVL_MASK_BIT]
            |=> ch1_overload_irq_q;
    endproperty
    a_ch1_unmasked: assert property (p_ch1_unmasked)
        else $error("Unmasked channel-1 overload not indicated");

    property p_mask_hold;
        !wr_mask |=> $stable(ovl_mask_q);
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("Mask register changed without a write");

    property p_bias_read_returns;
        rd_bias |=> reg_rdata_q == $past(bias_if.value);
    endproperty
    a_bias_read_returns: assert property (p_bias_read_returns)
        else $error("Read data differs from bias event register");

    c_ch2_read: cover property (rd_ch2 && ch2_if.value != 8'h00);
    c_mask_write: cover property (wr_mask && reg_wdata[fesb_pkg::FESB_CH1_OVL_MASK_BIT]);
    c_irq: cover property (ch1_overload_irq_q ##1 !ch1_overload_irq_q);
    c_live: cover property (live_sync_q != 5'h00);

endmodule

// *** fesb_fault_event_status_bank_test.sv ***
// Self-checking testbench for the fault and event status bank
module fesb_fault_event_status_bank_test;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata_q;
    logic [7:0] ch2_fault_raw = 8'h00;
    logic [7:0] headset_event_raw = 8'h00;
    logic [7:0] bias_event_raw = 8'h00;
    logic [4:0] clock_boost_raw = 5'h00;
    logic [1:0] overload_raw = 2'h0;
    logic ch1_overload_irq_q;
    logic ch2_overload_irq_q;
    int fails = 0;
    int tests_run = 0;
    integer seed = 77;
    logic [7:0] ofs [3] = '{fesb_pkg::FESB_OFS_CH2_FAULT, fesb_pkg::FESB_OFS_HEADSET, fesb_pkg::FESB_OFS_BIAS};
    logic [7:0] addr_tbl [8] = '{8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h00, 8'hff};
    int m_s1 [5] = '{0, 0, 0, 0, 0};
    int m_s2 [5] = '{0, 0, 0, 0, 0};
    int m_lt [3] = '{0, 0, 0};
    int m_mask = 0;
    int m_rd = 0;
    int m_irq1 = 0;
    int m_irq2 = 0;

    always #25 sys_clk = ~sys_clk;

    fesb_fault_event_status_bank DUT (
        .sys_clk(sys_clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q),
        .ch2_fault_raw(ch2_fault_raw),
        .headset_event_raw(headset_event_raw),
        .bias_event_raw(bias_event_raw),
        .clock_boost_raw(clock_boost_raw),
        .overload_raw(overload_raw),
        .ch1_overload_irq_q(ch1_overload_irq_q),
        .ch2_overload_irq_q(ch2_overload_irq_q)
    );

    // ****************************************************************
    // Reference model
    // ****************************************************************
    function automatic int model_read(input logic [7:0] a);
        if (a == fesb_pkg::FESB_OFS_CH2_FAULT) return m_lt[0];
        if (a == fesb_pkg::FESB_OFS_OVL_MASK) return m_mask;
        if (a == fesb_pkg::FESB_OFS_HEADSET) return m_lt[1];
        if (a == fesb_pkg::FESB_OFS_BIAS) return m_lt[2];
        if (a == fesb_pkg::FESB_OFS_LIVE) return m_s2[3] << 3;
        return 0;
    endfunction

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            m_s1 = '{0, 0, 0, 0, 0};
            m_s2 = '{0, 0, 0, 0, 0};
            m_lt = '{0, 0, 0};
            m_mask = 0;
            m_rd = 0;
            m_irq1 = 0;
            m_irq2 = 0;
        end else begin
            if (reg_rd) m_rd = model_read(reg_addr);
            m_irq1 = ((m_s2[4] >> 1) & 1) & (((m_mask >> 3) & 1) ^ 1);
            m_irq2 = (m_s2[4] & 1) & (((m_mask >> 2) & 1) ^ 1);
            for (int i = 0; i < 3; i++) begin
                m_lt[i] = (reg_rd && reg_addr == ofs[i]) ? m_s2[i] : (m_lt[i] | m_s2[i]);
            end
            if (reg_wr && reg_addr == fesb_pkg::FESB_OFS_OVL_MASK) m_mask = reg_wdata & 8'h0c;
            m_s2 = m_s1;
            m_s1 = '{ch2_fault_raw, headset_event_raw, bias_event_raw, clock_boost_raw, overload_raw};
        end
    end

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Every cycle against the model, once the edge has settled
    always @(posedge sys_clk) begin
        #2;
        chk(reg_rdata_q, 8'(m_rd));
        chk({7'h00, ch1_overload_irq_q}, 8'(m_irq1));
        chk({7'h00, ch2_overload_irq_q}, 8'(m_irq2));
    end

    initial begin
        #1000000;
        fails++;
        report_and_stop();
    end

    // ****************************************************************
    // Drivers
    // ****************************************************************
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
    endtask

    task automatic set_raw(input int idx, input logic [7:0] v);
        case (idx)
            0: ch2_fault_raw = v;
            1: headset_event_raw = v;
            2: bias_event_raw = v;
            3: clock_boost_raw = v[4:0];
            default: overload_raw = v[1:0];
        endcase
    endtask

    // One-cycle pulse on each bit, then read twice
    task automatic walk(input int r);
        for (int b = 0; b < 8; b++) begin
            set_raw(r, 8'h01 << b);
            idle(1);
            set_raw(r, 8'h00);
            idle(4);
            rd(ofs[r]);
            chk(reg_rdata_q, 8'h01 << b);
            rd(ofs[r]);
            chk(reg_rdata_q, 8'h00);
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        foreach (addr_tbl[i]) begin
            rd(addr_tbl[i]);
            chk(reg_rdata_q, 8'h00);
        end
        walk(0);
        walk(1);
        walk(2);
        // Condition present at the read keeps the bit
        set_raw(1, 8'h81);
        idle(4);
        rd(ofs[1]);
        rd(ofs[1]);
        chk(reg_rdata_q, 8'h81);
        set_raw(1, 8'h00);
        idle(3);
        rd(ofs[1]);
        chk(reg_rdata_q, 8'h81);
        rd(ofs[1]);
        chk(reg_rdata_q, 8'h00);
        // Live register follows the condition
        foreach (addr_tbl[i]) begin
            set_raw(3, 8'($random(seed)));
            idle(3);
            rd(fesb_pkg::FESB_OFS_LIVE);
            chk(reg_rdata_q, {clock_boost_raw, 3'h0});
        end
        // Mask register, reserved bits and read-only places
        wr(fesb_pkg::FESB_OFS_OVL_MASK, 8'hff);
        rd(fesb_pkg::FESB_OFS_OVL_MASK);
        chk(reg_rdata_q, 8'h0c);
        wr(fesb_pkg::FESB_OFS_CH2_FAULT, 8'hff);
        wr(fesb_pkg::FESB_OFS_LIVE, 8'hff);
        rd(fesb_pkg::FESB_OFS_CH2_FAULT);
        chk(reg_rdata_q, 8'h00);
        for (int m = 0; m < 4; m++) begin
            for (int o = 0; o < 4; o++) begin
                wr(fesb_pkg::FESB_OFS_OVL_MASK, 8'(m << 2));
                set_raw(4, 8'(o));
                idle(4);
                chk({7'h00, ch1_overload_irq_q}, 8'(((o >> 1) & 1) & ~(m >> 1) & 1));
                chk({7'h00, ch2_overload_irq_q}, 8'((o & 1) & ~m & 1));
            end
        end
        // Read and write at the same edge: old value returned
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b1;
        reg_wr = 1'b1;
        reg_addr = fesb_pkg::FESB_OFS_OVL_MASK;
        reg_wdata = 8'h04;
        idle(1);
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        chk(reg_rdata_q, 8'h0c);
        // Random traffic against the model
        for (int i = 0; i < 400; i++) begin
            for (int r = 0; r < 5; r++) set_raw(r, 8'($random(seed)) & 8'($random(seed)));
            reg_rd = 1'($random(seed));
            reg_wr = 1'($random(seed));
            reg_addr = addr_tbl[3'($random(seed))];
            reg_wdata = 8'($random(seed)) & 8'h0c;
            idle(1);
        end
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        // Reset in mid-run clears everything
        for (int r = 0; r < 5; r++) set_raw(r, 8'hff);
        idle(4);
        rst = 1'b1;
        for (int r = 0; r < 5; r++) set_raw(r, 8'h00);
        idle(2);
        rst = 1'b0;
        foreach (addr_tbl[i]) begin
            rd(addr_tbl[i]);
            chk(reg_rdata_q, 8'h00);
        end
        report_and_stop();
    end
endmodule
